// file: logic/ref_osc_trim_regs.sv
// Trim register pair of the internal 1 MHz reference oscillator, with its write guard.
// Assumes a synchronous register port, a factory trim word stable at reset release,
// and that PLL lock and oscillator-up flags are held elsewhere and cleared by pulse.
//
// Summary of operation
// - After reset release the factory trim word, with bit 10 cleared, is copied into both trim registers.
// - Trim registers read at any time and take writes only while the write guard is clear.
// - An accepted trim write while the PLL clock is selected clears the lock and osc-up flags.
// - Bits 15 to 11 of the pair hold the temperature trim and drive the compensation control.
// - Bits 9 to 0 hold the frequency trim, whose top four bits pick coarse steps.
// - The low six frequency bits pick fine steps.
// - Temperature codes 00000 and 10000 switch the compensation off.
// - The top temperature bit gives the direction and the lower four the magnitude.
// - Writing 26h to the guard register clears the guard and any other write sets it.
`timescale 1ns/100ps
`default_nettype none
module ref_osc_trim_regs
  import ref_osc_trim_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Register port
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Factory trim source
  input  wire logic [15:0] FLASH_TRIM,
  // Clock system status
  input  wire logic        PLL_CLOCK_SELECTED,
  output logic             LOCK_CLR,
  output logic             OSC_UP_CLR,
  // Oscillator controls
  output logic      [4:0]  TEMP_COEFF_TRIM,
  output logic      [3:0]  FREQ_COARSE,
  output logic      [5:0]  FREQ_FINE,
  output var  ref_osc_trim_pkg::tc_ctrl_s TC_CTRL,
  output logic             CONFIG_WRITE_GUARD,
  output logic             TRIM_LOADED
);
  import ref_osc_trim_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  trim_pair_s  trim_r;
  trim_pair_s  trim_nxt;
  logic        guard_r;
  logic        guard_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        clr_r;
  logic        clr_nxt;
  load_state_e state_r;
  load_state_e state_nxt;
  logic [1:0]  lane_we;
  logic [15:0] lane_bits;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic sel_high   = (ADDR == ADDR_TRIM_HIGH);
  wire logic sel_low    = (ADDR == ADDR_TRIM_LOW);
  wire logic sel_guard  = (ADDR == ADDR_GUARD);
  wire logic wr_open    = WR && !guard_r && (state_r == ST_RUN);
  wire logic wr_high    = wr_open && sel_high;
  wire logic wr_low     = wr_open && sel_low;
  wire logic wr_trim    = wr_high || wr_low;
  wire logic loading    = (state_r == ST_LOAD);

  wire logic [15:0] trim_bits = trim_r;
  wire logic [15:0] flash_bits = FLASH_TRIM;
  wire logic [7:0]  high_merge = (WDATA & HIGH_WR_MASK);

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  // Lane 1 is the high byte, lane 0 the low byte
  assign lane_we = {wr_high, wr_low};

  // Loading wins; a write cannot land in the load cycle anyway
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    wire logic [7:0] lane_wdata = (lane == 1) ? high_merge : WDATA;
    wire logic [7:0] lane_old   = trim_bits[lane*8 +: 8];
    wire logic [7:0] lane_flash = flash_bits[lane*8 +: 8];
    assign lane_bits[lane*8 +: 8] = loading       ? lane_flash :
                                    lane_we[lane] ? lane_wdata : lane_old;
  end

  // ----------------------------------------
  // Trim next value
  // ----------------------------------------
  // Bit 10 forced low here so it can never hold a value, even from flash
  always_comb begin
    trim_nxt        = lane_bits;
    trim_nxt.unused = 1'b0;
  end

  // ----------------------------------------
  // Guard
  // ----------------------------------------
  // Guard write is never itself guarded, so software can always unlock
  assign guard_nxt = (WR && sel_guard) ? (WDATA != GUARD_UNLOCK) : guard_r;

  // ----------------------------------------
  // Load sequencing
  // ----------------------------------------
  // One load cycle; an illegal code restarts the load rather than hang
  always_comb begin
    unique case (state_r)
      ST_LOAD: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_LOAD;
      end
    endcase
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire logic [7:0] rd_high  = trim_bits[15:8];
  wire logic [7:0] rd_low   = trim_bits[7:0];
  wire logic [7:0] rd_guard = {7'h00, guard_r};
  wire logic [7:0] rd_sel   = sel_high  ? rd_high :
                              sel_low   ? rd_low :
                              sel_guard ? rd_guard : RDATA_UNMAPPED;
  assign rdata_nxt = RD ? rd_sel : RDATA_UNMAPPED;

  // ----------------------------------------
  // Clear pulse
  // ----------------------------------------
  // Registered so the flag logic sees a clean one-cycle pulse
  assign clr_nxt = wr_trim && PLL_CLOCK_SELECTED;

  // ----------------------------------------
  // Trim and guard registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      trim_r <= TRIM_RESET;
    end else begin
      trim_r <= trim_nxt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      guard_r <= GUARD_RESET;
    end else begin
      guard_r <= guard_nxt;
    end
  end

  // ----------------------------------------
  // Status registers
  // ----------------------------------------
  // Read data falls back to zero one cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_r <= RDATA_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      clr_r <= 1'b0;
    end else begin
      clr_r <= clr_nxt;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  tc_ctrl_s tc_ctrl;

  tc_trim_decode u_tc_decode (
    .code (trim_r.temp_coeff_trim),
    .ctrl (tc_ctrl)
  );

  assign RDATA              = rdata_r;
  assign LOCK_CLR           = clr_r;
  assign OSC_UP_CLR         = clr_r;
  assign TEMP_COEFF_TRIM    = trim_bits[TC_MSB:TC_LSB];
  assign FREQ_COARSE        = trim_bits[FREQ_MSB:COARSE_LSB];
  assign FREQ_FINE          = trim_bits[FINE_MSB:0];
  assign TC_CTRL            = tc_ctrl;
  assign CONFIG_WRITE_GUARD = guard_r;
  assign TRIM_LOADED        = (state_r == ST_RUN);

endmodule // ref_osc_trim_regs
`default_nettype wire

// file: include/ref_osc_trim_pkg.sv
// Constants and types shared by the reference oscillator trim register block.
// Assumes an 8-bit register port whose addresses are byte addresses.
package ref_osc_trim_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADDR_TRIM_HIGH  = 16'h02F8;
  localparam logic [15:0] ADDR_TRIM_LOW   = 16'h02F9;
  localparam logic [15:0] ADDR_GUARD      = 16'h02FB;

  // ----------------------------------------
  // Field layout of the trim pair
  // ----------------------------------------
  localparam int          TC_MSB          = 15;
  localparam int          TC_LSB          = 11;
  localparam int          UNUSED_BIT      = 10;
  localparam int          FREQ_MSB        = 9;
  localparam int          COARSE_LSB      = 6;
  localparam int          FINE_MSB        = 5;
  localparam logic [7:0]  HIGH_WR_MASK    = 8'hFB;

  // ----------------------------------------
  // Values after reset and codes
  // ----------------------------------------
  localparam logic [15:0] TRIM_RESET      = 16'h0000;
  localparam logic        GUARD_RESET     = 1'b0;
  localparam logic [7:0]  GUARD_UNLOCK    = 8'h26;
  localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;
  localparam logic [3:0]  TC_MAG_OFF      = 4'h0;

  typedef struct packed {
    logic [4:0] temp_coeff_trim;
    logic       unused;
    logic [9:0] ref_freq_trim;
  } trim_pair_s;

  typedef struct packed {
    logic       comp_on;
    logic       dir_positive;
    logic [3:0] magnitude;
  } tc_ctrl_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } load_state_e;

endpackage

// file: logic/tc_trim_decode.sv
// Decoder for the temperature-coefficient trim code.
// Assumes a stable 5-bit code from the trim register.
`timescale 1ns/100ps
`default_nettype none
module tc_trim_decode
  import ref_osc_trim_pkg::*;
(
  // Trim code in
  input  wire logic [4:0] code,
  // Compensation control out
  output var  ref_osc_trim_pkg::tc_ctrl_s ctrl
);
  import ref_osc_trim_pkg::*;

  wire logic [3:0] mag  = code[3:0];
  wire logic       dir  = code[4];
  wire logic       on   = (mag != TC_MAG_OFF);

  // ----------------------------------------
  // Direction and magnitude
  // ----------------------------------------
  assign ctrl = '{comp_on: on, dir_positive: dir, magnitude: mag};

endmodule // tc_trim_decode
`default_nettype wire

// file: sim/ref_osc_trim_regs_asserts.sv
// Checker for the oscillator trim register block.
// Assumes it is bound to ref_osc_trim_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ref_osc_trim_asserts (
  // Bus side
  input wire logic                      REF_CLK, RESET, WR, RD,
  input wire logic [15:0]               ADDR, FLASH_TRIM,
  input wire logic [7:0]                WDATA, RDATA,
  // Oscillator side
  input wire logic                      PLL_CLOCK_SELECTED, LOCK_CLR, OSC_UP_CLR,
  input wire logic                      CONFIG_WRITE_GUARD, TRIM_LOADED,
  input wire logic [4:0]                TEMP_COEFF_TRIM,
  input wire logic [3:0]                FREQ_COARSE,
  input wire logic [5:0]                FREQ_FINE,
  input wire ref_osc_trim_pkg::tc_ctrl_s TC_CTRL
);
  import ref_osc_trim_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wire       trim_a = ADDR == ADDR_TRIM_HIGH || ADDR == ADDR_TRIM_LOW;
  wire       wr_ok  = WR && trim_a && !CONFIG_WRITE_GUARD && TRIM_LOADED;
  wire [7:0] hi     = {TEMP_COEFF_TRIM, 1'h0, FREQ_COARSE[3:2]};
  wire [7:0] lo     = {FREQ_COARSE[1:0], FREQ_FINE};
  // ----------
  // Properties
  // ----------
  property p_load; $rose(TRIM_LOADED) |-> {hi, lo} == (FLASH_TRIM & 16'hFBFF); endproperty
  a_load: assert property (p_load) else $error("bad load");
  property p_lo; wr_ok && ADDR == ADDR_TRIM_LOW |=> lo == $past(WDATA); endproperty
  a_lo: assert property (p_lo) else $error("bad low write");
  property p_hi; wr_ok && ADDR == ADDR_TRIM_HIGH |=> hi == ($past(WDATA) & HIGH_WR_MASK); endproperty
  a_hi: assert property (p_hi) else $error("bad high write");
  property p_blk; WR && trim_a && CONFIG_WRITE_GUARD |=> $stable({hi, lo}); endproperty
  a_blk: assert property (p_blk) else $error("guarded write taken");
  property p_clr; wr_ok && PLL_CLOCK_SELECTED |=> LOCK_CLR && OSC_UP_CLR; endproperty
  a_clr: assert property (p_clr) else $error("no clear pulse");
  property p_src; LOCK_CLR || OSC_UP_CLR |-> $past(wr_ok) && $past(PLL_CLOCK_SELECTED); endproperty
  a_src: assert property (p_src) else $error("stray clear pulse");
  property p_grd; WR && ADDR == ADDR_GUARD |=> CONFIG_WRITE_GUARD == ($past(WDATA) != GUARD_UNLOCK); endproperty
  a_grd: assert property (p_grd) else $error("bad guard");
  property p_tc; TC_CTRL == {TEMP_COEFF_TRIM[3:0] != TC_MAG_OFF, TEMP_COEFF_TRIM}; endproperty
  a_tc: assert property (p_tc) else $error("bad decode");
  property p_rd; RD && ADDR == ADDR_TRIM_HIGH |=> RDATA == $past(hi); endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  c_clr: cover property (wr_ok && PLL_CLOCK_SELECTED);
  c_blk: cover property (WR && trim_a && CONFIG_WRITE_GUARD);
  c_unl: cover property (WR && ADDR == ADDR_GUARD && WDATA == GUARD_UNLOCK);
endmodule // ref_osc_trim_asserts
bind ref_osc_trim_regs ref_osc_trim_asserts i_ref_osc_trim_asserts (.*);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the oscillator trim register block.
// Assumes the checker is bound in; reads are scored from a queue.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ref_osc_trim_pkg::*;
  logic        REF_CLK = 1'h0, RESET = 1'h1, WR = 1'h0, RD = 1'h0, PLL_CLOCK_SELECTED = 1'h0;
  logic        LOCK_CLR, OSC_UP_CLR, CONFIG_WRITE_GUARD, TRIM_LOADED, rd_d = 1'h0, g;
  logic [15:0] ADDR = 16'h0000, FLASH_TRIM, m;
  logic [7:0]  WDATA = 8'h00, RDATA, q[$];
  logic [4:0]  TEMP_COEFF_TRIM;
  logic [3:0]  FREQ_COARSE;
  logic [5:0]  FREQ_FINE;
  tc_ctrl_s    TC_CTRL;
  logic [31:0] v;
  int          fails = 0, n_tests = 0, seed = 44, i;
  ref_osc_trim_regs i_ref_osc_trim_regs (.*);
  initial forever #4 REF_CLK = ~REF_CLK;
  task chk(input string nm, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d, input logic p);
    @(posedge REF_CLK);
    {ADDR, WDATA, WR, PLL_CLOCK_SELECTED} <= {a, d, 1'h1, p};
    @(posedge REF_CLK);
    WR <= 1'h0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge REF_CLK);
    {ADDR, RD} <= {a, 1'h1};
    @(posedge REF_CLK);
    RD <= 1'h0;
  endtask
  always @(posedge REF_CLK) rd_d <= RD;
  always @(negedge REF_CLK) if (rd_d === 1'h1) chk("RDATA", RDATA, q.pop_front());
  initial begin
    v = $random(seed);
    FLASH_TRIM = v[15:0];
    m = v[15:0] & 16'hFBFF;
    repeat (20) @(posedge REF_CLK);
    RESET <= 1'h0;
    rd(ADDR_TRIM_HIGH, m[15:8]);
    rd(ADDR_TRIM_LOW, m[7:0]);
    rd(16'h02FA, RDATA_UNMAPPED);
    chk("TRIM_LOADED", {7'h00, TRIM_LOADED}, 8'h01);
    for (i = 0; i < 40; i++) begin
      v = $random(seed);
      // First two passes switch compensation off both ways
      if (i < 2) v[10:0] = {3'h6, i[0], 7'h00};
      wr(ADDR_GUARD, v[9] ? GUARD_UNLOCK : v[7:0], v[8]);
      g = !v[9] && v[7:0] != GUARD_UNLOCK;
      wr(v[10] ? ADDR_TRIM_HIGH : ADDR_TRIM_LOW, v[7:0], v[8]);
      @(negedge REF_CLK);
      chk("LOCK_CLR", {7'h00, LOCK_CLR}, {7'h00, !g && v[8]});
      chk("OSC_UP_CLR", {7'h00, OSC_UP_CLR}, {7'h00, !g && v[8]});
      if (!g && v[10]) m[15:8] = v[7:0] & HIGH_WR_MASK;
      if (!g && !v[10]) m[7:0] = v[7:0];
      if (!g && v[10]) begin
        wr(ADDR_TRIM_LOW, v[23:16], v[8]);
        m[7:0] = v[23:16];
      end
      rd(ADDR_TRIM_HIGH, m[15:8]);
      rd(ADDR_TRIM_LOW, m[7:0]);
      rd(ADDR_GUARD, {7'h00, g});
      @(negedge REF_CLK);
      chk("TC_CTRL", {2'h0, TC_CTRL}, {2'h0, m[14:11] != 4'h0, m[15:11]});
      chk("TRIM_HIGH", {TEMP_COEFF_TRIM, 1'h0, FREQ_COARSE[3:2]}, m[15:8]);
      chk("TRIM_LOW", {FREQ_COARSE[1:0], FREQ_FINE}, m[7:0]);
      chk("GUARD", {7'h00, CONFIG_WRITE_GUARD}, {7'h00, g});
    end
    finish_test;
  end
endmodule // tb
`default_nettype wire
